// >>> verilog/cossd_pkg.sv
// constants, field layout and carrier types of the shutdown/steering block
// assumes one 100 MHz clock and a plain register port with 8-bit data
package cossd_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_SHUTDOWN_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_SHUTDOWN_SOURCE_ENABLES = 3'h1;
   localparam logic [2:0] ADDR_OUTPUT_STEERING = 3'h2;
   localparam logic [2:0] ADDR_RISING_DEADBAND_COUNT = 3'h3;
   localparam logic [2:0] ADDR_FALLING_DEADBAND_COUNT = 3'h4;
   localparam logic [2:0] ADDR_RISING_BLANKING_COUNT = 3'h5;
   localparam logic [2:0] ADDR_FALLING_BLANKING_COUNT = 3'h6;
   localparam logic [2:0] ADDR_POLARITY_CONTROL = 3'h7;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int STATUS_BIT = 7;
   localparam int RESTART_BIT = 6;
   localparam int OVR_BD_LSB = 4;
   localparam int OVR_AC_LSB = 2;
   localparam int STATIC_LSB = 4;
   localparam int RDBS_BIT = 7;
   localparam int FDBS_BIT = 6;
   localparam int COUNT_W = 6;
   // ---------------------------------------------------------------
   // reset values and masks
   // ---------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_MASK = 8'hfc;
   localparam logic [7:0] SOURCE_MASK = 8'h0f;
   localparam logic [7:0] COUNT_MASK = 8'h3f;
   localparam logic [7:0] POLARITY_MASK = 8'hcf;
   // ---------------------------------------------------------------
   // override encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] OVR_INACTIVE = 2'h0;
   localparam logic [1:0] OVR_TRISTATE = 2'h1;
   localparam logic [1:0] OVR_LOW = 2'h2;
   localparam logic [1:0] OVR_HIGH = 2'h3;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cossd_bus_t;
   typedef struct packed {
      logic logic_cell_two_output;
      logic comparator_two;
      logic comparator_one;
      logic selected_input_pin;
   } cossd_src_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SHUT = 2'b01,
      ST_EXIT = 2'b10
   } cossd_state_t;
endpackage

// >>> verilog/cossd_top.sv
// shutdown, steering, dead-band and blanking of a four-output generator
// assumes synchronous rise/fall event pulses and sources, delay chain tick input
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cossd_top #(
   parameter int COUNT_W = 6
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire cossd_pkg::cossd_bus_t bus,
   output logic [7:0] rdata,
   // events and sources
   input wire logic rise_event,
   input wire logic fall_event,
   input wire logic chain_tick,
   input wire cossd_pkg::cossd_src_t src,
   // outputs: a, b, c, d in bits 0..3
   output logic [3:0] drive_out,
   output logic [3:0] drive_out_oe_n
);
   logic [7:0] ctrl_reg;
   logic [3:0] src_en_reg;
   logic [7:0] steer_reg;
   logic [COUNT_W-1:0] rise_deadband_count, fall_deadband_count;
   logic [COUNT_W-1:0] rise_blank_count, fall_blank_count;
   logic [5:0] pol_reg;
   cossd_pkg::cossd_state_t state_reg;
   logic [COUNT_W-1:0] rdb_cnt_reg, fdb_cnt_reg, rblk_cnt_reg, fblk_cnt_reg;
   logic wave_reg, prim_reg, comp_reg;
   logic [3:0] polarity;
   logic rise_deadband_source_sel, fall_deadband_source_sel;
   logic rise_ok, fall_ok, fault, wr_ctrl;
   assign polarity = pol_reg[3:0];
   assign rise_deadband_source_sel = pol_reg[5];
   assign fall_deadband_source_sel = pol_reg[4];
   assign wr_ctrl = bus.wr && bus.addr == cossd_pkg::ADDR_SHUTDOWN_CONTROL;
   // ---------------------------------------------------------------
   // shutdown sources
   // ---------------------------------------------------------------
   assign fault = (src_en_reg[3] && !src.logic_cell_two_output)
      || (src_en_reg[2] && !src.comparator_two)
      || (src_en_reg[1] && !src.comparator_one)
      || (src_en_reg[0] && !src.selected_input_pin);
   // ---------------------------------------------------------------
   // blanking gates event inputs
   // ---------------------------------------------------------------
   assign rise_ok = rise_event && fblk_cnt_reg == '0;
   assign fall_ok = fall_event && rblk_cnt_reg == '0 && !rise_ok;
   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         src_en_reg <= 4'h0;
         steer_reg <= 8'h00;
         rise_deadband_count <= '0;
         fall_deadband_count <= '0;
         rise_blank_count <= '0;
         fall_blank_count <= '0;
         pol_reg <= 6'h00;
      end else if (bus.wr) begin
         unique case (bus.addr)
            cossd_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES: src_en_reg <= bus.wdata[3:0];
            cossd_pkg::ADDR_OUTPUT_STEERING: steer_reg <= bus.wdata;
            cossd_pkg::ADDR_RISING_DEADBAND_COUNT: rise_deadband_count <= bus.wdata[COUNT_W-1:0];
            cossd_pkg::ADDR_FALLING_DEADBAND_COUNT: fall_deadband_count <= bus.wdata[COUNT_W-1:0];
            cossd_pkg::ADDR_RISING_BLANKING_COUNT: rise_blank_count <= bus.wdata[COUNT_W-1:0];
            cossd_pkg::ADDR_FALLING_BLANKING_COUNT: fall_blank_count <= bus.wdata[COUNT_W-1:0];
            cossd_pkg::ADDR_POLARITY_CONTROL: pol_reg <= {bus.wdata[7:6], bus.wdata[3:0]};
            default: ;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // control register, restart enable and override fields
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg <= cossd_pkg::CONTROL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= bus.wdata & cossd_pkg::CONTROL_MASK;
      end
   end
   // ---------------------------------------------------------------
   // shutdown state; a fault wins over a software clear
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= cossd_pkg::ST_RUN;
      end else if (fault) begin
         state_reg <= cossd_pkg::ST_SHUT;
      end else begin
         unique case (state_reg)
            cossd_pkg::ST_RUN: state_reg <= cossd_pkg::ST_RUN;
            cossd_pkg::ST_SHUT: begin
               if (wr_ctrl && !bus.wdata[cossd_pkg::STATUS_BIT]) begin
                  state_reg <= cossd_pkg::ST_EXIT;
               end else if (ctrl_reg[cossd_pkg::RESTART_BIT]) begin
                  state_reg <= cossd_pkg::ST_EXIT;
               end
            end
            cossd_pkg::ST_EXIT: begin
               if (rise_ok) begin
                  state_reg <= cossd_pkg::ST_RUN;
               end
            end
            default: state_reg <= cossd_pkg::ST_SHUT;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // blanking counters
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rblk_cnt_reg <= '0;
         fblk_cnt_reg <= '0;
      end else begin
         if (rise_ok) begin
            rblk_cnt_reg <= rise_blank_count;
         end else if (rblk_cnt_reg != '0) begin
            rblk_cnt_reg <= rblk_cnt_reg - 1'b1;
         end
         if (fall_ok) begin
            fblk_cnt_reg <= fall_blank_count;
         end else if (fblk_cnt_reg != '0) begin
            fblk_cnt_reg <= fblk_cnt_reg - 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // dead-band: count clocks or delay chain ticks
   // ---------------------------------------------------------------
   logic rdb_step, fdb_step;
   assign rdb_step = rise_deadband_source_sel ? chain_tick : 1'b1;
   assign fdb_step = fall_deadband_source_sel ? chain_tick : 1'b1;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wave_reg <= 1'b0;
         rdb_cnt_reg <= '0;
         fdb_cnt_reg <= '0;
         prim_reg <= 1'b0;
         comp_reg <= 1'b0;
      end else begin
         if (rise_ok) begin
            wave_reg <= 1'b1;
            comp_reg <= 1'b0;
            rdb_cnt_reg <= rise_deadband_count;
            if (rise_deadband_count == '0) begin
               prim_reg <= 1'b1;
            end
         end else if (fall_ok) begin
            wave_reg <= 1'b0;
            prim_reg <= 1'b0;
            fdb_cnt_reg <= fall_deadband_count;
            if (fall_deadband_count == '0) begin
               comp_reg <= 1'b1;
            end
         end else begin
            if (wave_reg && !prim_reg && rdb_step) begin
               if (rdb_cnt_reg <= 1) begin
                  prim_reg <= 1'b1;
               end
               rdb_cnt_reg <= rdb_cnt_reg - 1'b1;
            end
            if (!wave_reg && !comp_reg && fdb_step && fdb_cnt_reg != '0) begin
               if (fdb_cnt_reg == 1) begin
                  comp_reg <= 1'b1;
               end
               fdb_cnt_reg <= fdb_cnt_reg - 1'b1;
            end
         end
      end
   end
   // ---------------------------------------------------------------
   // output steering per output, shutdown override per output pair (a/c, b/d)
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_out
         logic raw, lvl;
         logic [1:0] ovr;
         assign raw = (gi % 2 == 0) ? prim_reg : comp_reg;
         assign ovr = (gi % 2 == 0) ? ctrl_reg[cossd_pkg::OVR_AC_LSB +: 2] : ctrl_reg[cossd_pkg::OVR_BD_LSB +: 2];
         assign lvl = steer_reg[gi] ? (raw ^ polarity[gi])
            : steer_reg[cossd_pkg::STATIC_LSB + gi];
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               drive_out[gi] <= 1'b0;
               drive_out_oe_n[gi] <= 1'b0;
            end else if (state_reg != cossd_pkg::ST_RUN) begin
               unique case (ovr)
                  cossd_pkg::OVR_HIGH: drive_out[gi] <= 1'b1;
                  cossd_pkg::OVR_LOW: drive_out[gi] <= 1'b0;
                  cossd_pkg::OVR_TRISTATE: drive_out[gi] <= 1'b0;
                  cossd_pkg::OVR_INACTIVE: drive_out[gi] <= polarity[gi];
               endcase
               drive_out_oe_n[gi] <= ovr == cossd_pkg::OVR_TRISTATE;
            end else begin
               drive_out[gi] <= lvl;
               drive_out_oe_n[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   // ---------------------------------------------------------------
   // read port, one cycle latency
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            cossd_pkg::ADDR_SHUTDOWN_CONTROL:
               rdata <= {state_reg == cossd_pkg::ST_SHUT, ctrl_reg[6:2], 2'b00};
            cossd_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES: rdata <= {4'h0, src_en_reg};
            cossd_pkg::ADDR_OUTPUT_STEERING: rdata <= steer_reg;
            cossd_pkg::ADDR_RISING_DEADBAND_COUNT: rdata <= 8'(rise_deadband_count);
            cossd_pkg::ADDR_FALLING_DEADBAND_COUNT: rdata <= 8'(fall_deadband_count);
            cossd_pkg::ADDR_RISING_BLANKING_COUNT: rdata <= 8'(rise_blank_count);
            cossd_pkg::ADDR_FALLING_BLANKING_COUNT: rdata <= 8'(fall_blank_count);
            cossd_pkg::ADDR_POLARITY_CONTROL: rdata <= {pol_reg[5:4], 2'b00, pol_reg[3:0]};
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// >>> testbench/cossd_assertions.sv
// port checker for the shutdown/steering block
// assumes writes land in the registers on the edge after the strobe
`timescale 1ns/1ps
module cossd_assertions #(
   parameter int COUNT_W = 6
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire cossd_pkg::cossd_bus_t bus,
   input wire logic [7:0] rdata,
   // events and sources
   input wire logic rise_event,
   input wire logic fall_event,
   input wire logic chain_tick,
   input wire cossd_pkg::cossd_src_t src,
   // outputs
   input wire logic [3:0] drive_out,
   input wire logic [3:0] drive_out_oe_n
);
   logic [3:0] ovr;
   logic [3:0] en;
   logic fault;
   // shadow of override fields and source enables
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovr <= 4'h0;
      end else if (bus.wr && bus.addr == cossd_pkg::ADDR_SHUTDOWN_CONTROL) begin
         ovr <= bus.wdata[5:2];
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         en <= 4'h0;
      end else if (bus.wr && bus.addr == cossd_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES) begin
         en <= bus.wdata[3:0];
      end
   end
   assign fault = |(en & ~src);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("rdata not zero outside a read");
   src_pad_a: assert property ($past(bus.rd) && $past(bus.addr) == 3'h1 |-> rdata[7:4] == 4'h0)
      else $error("source enables upper bits not zero");
   ctl_pad_a: assert property ($past(bus.rd) && $past(bus.addr) == 3'h0 |-> rdata[1:0] == 2'h0)
      else $error("control low bits not zero");
   cnt_pad_a: assert property ($past(bus.rd) && $past(bus.addr) inside {[3'h3:3'h6]} |-> rdata[7:6] == 2'h0)
      else $error("count upper bits not zero");
   tri_ac_a: assert property (drive_out_oe_n[0] || drive_out_oe_n[2] |-> $past(ovr[1:0]) == 2'h1)
      else $error("a/c released without tristate code");
   tri_bd_a: assert property (drive_out_oe_n[1] || drive_out_oe_n[3] |-> $past(ovr[3:2]) == 2'h1)
      else $error("b/d released without tristate code");
   ovr_ac_a: assert property (fault && ovr[1] |-> ##3 drive_out[0] == $past(ovr[0], 3)
      && drive_out[2] == $past(ovr[0], 3) && !drive_out_oe_n[0]) else $error("a/c override level wrong");
   ovr_bd_a: assert property (fault && ovr[3] |-> ##3 drive_out[1] == $past(ovr[2], 3)
      && drive_out[3] == $past(ovr[2], 3) && !drive_out_oe_n[1]) else $error("b/d override level wrong");
   cover property (fault);
   cover property (drive_out_oe_n == 4'hf);
   cover property (fall_event && !rise_event);
endmodule
bind cossd_top cossd_assertions #(.COUNT_W(COUNT_W)) cossd_assertions_inst (.ref_clk(ref_clk), .rst(rst),
   .bus(bus), .rdata(rdata), .rise_event(rise_event), .fall_event(fall_event), .chain_tick(chain_tick),
   .src(src), .drive_out(drive_out), .drive_out_oe_n(drive_out_oe_n));

// >>> testbench/cossd_partner.sv
// fault sources and switch-driver pin load
// assumes fault bit n pulls the source of enable bit n low
`timescale 1ns/1ps
module cossd_partner (
   // clock
   input wire logic ref_clk,
   // commands and block pins
   input wire logic [3:0] fault,
   input wire logic [3:0] drive_out,
   input wire logic [3:0] drive_out_oe_n,
   // sources and resolved pins
   output cossd_pkg::cossd_src_t src,
   output logic [3:0] pin
);
   logic [3:0] last = 4'h0;
   // a commanded fault pulls its source low
   assign src = ~fault;
   // a released pin shows the inverse of its last level
   assign pin = (drive_out & ~drive_out_oe_n) | (~last & drive_out_oe_n);
   always @(posedge ref_clk) last <= pin;
endmodule

// >>> testbench/tb.sv
// self-checking bench for the shutdown/steering block
// assumes the partner supplies sources; counts run on ref_clk, or on chain_tick where the dead-band source selects it
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   cossd_pkg::cossd_bus_t bus = '0;
   logic rise_event = 1'b0;
   logic fall_event = 1'b0;
   logic chain_tick = 1'b1;
   logic [3:0] fault = 4'h0;
   cossd_pkg::cossd_src_t src;
   logic [7:0] rdata, d, r, p;
   logic [3:0] drive_out, drive_out_oe_n, pin;
   int n_fail = 0;
   int comparisons = 0;
   int n;
   always #5 ref_clk = ~ref_clk;
   cossd_top cossd_top_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .rise_event(rise_event),
      .fall_event(fall_event), .chain_tick(chain_tick), .src(src), .drive_out(drive_out),
      .drive_out_oe_n(drive_out_oe_n));
   cossd_partner cossd_partner_inst (.ref_clk(ref_clk), .fault(fault), .drive_out(drive_out),
      .drive_out_oe_n(drive_out_oe_n), .src(src), .pin(pin));
   task automatic complete_run();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] v);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic ev(logic rise, logic fall);
      @(posedge ref_clk);
      rise_event <= rise;
      fall_event <= fall;
      @(posedge ref_clk);
      rise_event <= 1'b0;
      fall_event <= 1'b0;
      #1;
   endtask
   task automatic lat(int i, output int k);
      k = 0;
      while (drive_out[i] !== 1'b1) begin
         cyc(1);
         k++;
         if (k > 80) begin
            n_fail++;
            complete_run();
         end
      end
   endtask
   function automatic logic [7:0] msk(logic [2:0] a);
      case (a)
         3'h0: return cossd_pkg::CONTROL_MASK & 8'h7f;
         3'h1: return cossd_pkg::SOURCE_MASK;
         3'h2: return 8'hff;
         3'h7: return cossd_pkg::POLARITY_MASK;
         default: return cossd_pkg::COUNT_MASK;
      endcase
   endfunction
   function automatic logic [3:0] ovr(logic [1:0] c, logic [3:0] pol);
      case (c)
         2'h3: return 4'hf;
         2'h0: return pol;
         default: return 4'h0;
      endcase
   endfunction
   initial begin
      void'($urandom(32'h217e));
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], d);
         check("reset", d, 8'h00);
         r = $urandom;
         wr(a[2:0], r & 8'h7f);
         rd(a[2:0], d);
         check("rw", d, r & 8'h7f & msk(a[2:0]));
      end
      @(posedge ref_clk) rst <= 1'b1;
      @(posedge ref_clk) rst <= 1'b0;
      for (int j = 0; j < 6; j++) begin
         r = $urandom;
         p = $urandom;
         wr(3'h7, {4'h0, p[3:0]});
         wr(3'h2, r);
         cyc(3);
         check("steer", drive_out, (r[3:0] & p[3:0]) | (~r[3:0] & r[7:4]));
      end
      wr(3'h2, 8'h0f);
      wr(3'h7, 8'h00);
      for (int j = 0; j < 3; j++) begin
         r = 8'($urandom_range(12));
         wr(3'h3, r);
         wr(3'h4, r + 8'h1);
         ev(1'b1, 1'b0);
         lat(0, n);
         check("rise db", 8'(n), r + 8'h1);
         ev(1'b0, 1'b1);
         lat(1, n);
         check("fall db", 8'(n), r + 8'h2);
      end
      wr(3'h7, 8'hc0);
      wr(3'h3, 8'h03);
      wr(3'h4, 8'h03);
      for (int j = 0; j < 2; j++) begin
         @(posedge ref_clk) chain_tick <= 1'b0;
         ev(j == 0, j == 1);
         cyc(8);
         check("chain hold", drive_out[j], 8'h00);
         @(posedge ref_clk) chain_tick <= 1'b1;
         lat(j, n);
         check("chain run", 8'(n < 20), 8'h01);
      end
      wr(3'h7, 8'h00);
      wr(3'h5, 8'h06);
      wr(3'h6, 8'h06);
      ev(1'b1, 1'b0);
      ev(1'b0, 1'b1);
      cyc(3);
      check("blank rise", drive_out[1:0], 8'h01);
      cyc(6);
      ev(1'b0, 1'b1);
      ev(1'b1, 1'b0);
      cyc(3);
      check("blank fall", drive_out[1:0], 8'h02);
      wr(3'h5, 8'h00);
      wr(3'h6, 8'h00);
      for (int c = 0; c < 4; c++) begin
         p = $urandom;
         wr(3'h7, {4'h0, p[3:0]});
         wr(3'h1, 8'h01 << c);
         wr(3'h0, {2'h0, c[1:0], c[1:0], 2'h0});
         @(posedge ref_clk) fault <= ~(4'h1 << c);
         cyc(4);
         rd(3'h0, d);
         check("ignored", d[7], 8'h00);
         @(posedge ref_clk) fault <= 4'hf;
         cyc(4);
         check("override", drive_out, ovr(c[1:0], p[3:0]));
         check("release", drive_out_oe_n, (c == 1) ? 8'h0f : 8'h00);
         rd(3'h0, d);
         check("status set", d[7], 8'h01);
         @(posedge ref_clk) fault <= 4'h0;
         cyc(4);
         rd(3'h0, d);
         check("held", d[7], 8'h01);
         wr(3'h0, {2'h0, c[1:0], c[1:0], 2'h0});
         rd(3'h0, d);
         check("cleared", d[7], 8'h00);
         ev(1'b1, 1'b0);
         cyc(4);
      end
      wr(3'h0, 8'h40);
      @(posedge ref_clk) fault <= 4'hf;
      cyc(4);
      @(posedge ref_clk) fault <= 4'h0;
      cyc(4);
      rd(3'h0, d);
      check("auto exit", d[7], 8'h00);
      ev(1'b1, 1'b0);
      cyc(4);
      check("restart", drive_out[0], {7'h0, ~p[0]});
      complete_run();
   end
endmodule
